// >>> pll_ctrl_pkg.sv
package pll_ctrl_pkg;
    // Register byte offsets
    localparam logic [9:0] OFS_IDENTITY   = 10'h000;
    localparam logic [9:0] OFS_CONTROL    = 10'h100;
    localparam logic [9:0] OFS_MULT       = 10'h110;
    localparam logic [9:0] OFS_PRE_DIVIDER_CONTROL     = 10'h114;
    localparam logic [9:0] OFS_DIV1       = 10'h118;
    localparam logic [9:0] OFS_DIV2       = 10'h11c;
    localparam logic [9:0] OFS_DIV3       = 10'h120;
    localparam logic [9:0] OFS_POST_DIVIDER_CONTROL    = 10'h128;
    localparam logic [9:0] OFS_BYPASS_CLOCK_DIVIDER      = 10'h12c;
    localparam logic [9:0] OFS_COMMAND    = 10'h138;
    localparam logic [9:0] OFS_STATUS     = 10'h13c;
    localparam logic [9:0] OFS_ALIGN      = 10'h140;
    localparam logic [9:0] OFS_CHANGE     = 10'h144;
    localparam logic [9:0] OFS_AUXEN      = 10'h148;
    localparam logic [9:0] OFS_AUXSTAT    = 10'h14c;
    localparam logic [9:0] OFS_DOMSTAT    = 10'h150;
    localparam logic [9:0] OFS_DIV4       = 10'h160;
    // Control register fields
    localparam int CTL_REF_SEL   = 8;
    localparam int CTL_EN_SRC    = 5;
    localparam int CTL_DISABLE   = 4;
    localparam int CTL_RESET     = 3;
    localparam int CTL_PWRDN     = 1;
    localparam int CTL_MODE_EN   = 0;
    localparam logic [8:0] CTL_WMASK = 9'h13b;
    localparam logic [8:0] CTL_RESET_VAL = 9'h07a;
    // Identity fields (values arbitrary)
    localparam logic [7:0] ID_TYPE  = 8'h5a;
    localparam logic [7:0] ID_CLASS = 8'h3c;
    localparam logic [7:0] ID_REV   = 8'h21;
    // Divider fields
    localparam int RATIO_W  = 5;
    localparam int DIV_EN   = 15;
    localparam int NUM_DOM  = 4;
    localparam logic [7:0] MULT_RESET    = 8'h5b;
    localparam logic [4:0] RATIO_RESET   = 5'h00;
    localparam logic [4:0] PRE_DIVIDER_CONTROL_RESET  = 5'h07;
    localparam logic [4:0] BYPASS_CLOCK_DIVIDER_RESET   = 5'h02;
    localparam logic [3:0] ALIGN_RESET   = 4'hf;
    localparam logic [3:0] AUXEN_RESET   = 4'h1;
    localparam int CMD_GO   = 0;
    localparam int STAT_GO  = 0;
endpackage

// >>> pll_config_and_divider_go.sv
// What this block does
// - Mode enable ignored while source select set
// - Ratio writes stay pending until GO
// - Writing go bit starts GO
// - Aligned clocks stop low, restart together
// - Unaligned clocks run on unchanged
// - Go status reads one during GO
// - Aligned clocks realign even if unchanged
// - Changed ratio sets change status bit
// - Powered down keeps reference-derived clocks
// - Identity register read-only fixed fields
// - Reset leaves controller in bypass
// - Control bit positions fixed
// - PLL multiplies by field plus one
//
// Implementation choice: the address-and-strobe port.
module pll_config_and_divider_go
    import pll_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Register port
    input  wire logic [9:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Analog PLL controls
    output logic             o_pll_mode,
    output logic             o_pll_reset,
    output logic             o_pll_disable,
    output logic             o_pll_power_down,
    output logic             o_ref_clock_select,
    output logic      [8:0]  o_pll_multiply,
    output logic      [4:0]  o_pre_divide,
    output logic      [4:0]  o_post_divide,
    // Test-hardware mode request, used while source select is set
    input  wire logic        i_test_mode_en,
    // Domain clock levels, high for about half of each ratio-plus-one period
    output logic      [3:0]  o_domain_clock_n,
    output logic             o_go_busy
);

    typedef enum logic [2:0] {
        GO_IDLE  = 3'b001,
        GO_PAUSE = 3'b010,
        GO_START = 3'b100
    } go_state_e;

    logic [8:0]  ctl_q;
    logic [7:0]  mult_q;
    logic [4:0]  pre_divider_control_q;
    logic [4:0]  post_divider_control_q;
    logic [4:0]  bypass_clock_divider_q;
    logic [4:0]  ratio_q [NUM_DOM];
    logic [4:0]  active_q [NUM_DOM];
    logic [4:0]  cnt_q [NUM_DOM];
    logic [3:0]  phase_q;
    logic [3:0]  align_q;
    logic [3:0]  change_q;
    logic [3:0]  auxen_q;
    logic [3:0]  hold_q;
    go_state_e   go_q;
    logic        test_s1_q;
    logic        test_s2_q;
    logic        test_s3_q;
    logic        test_q;
    logic        go_req;
    logic [3:0]  dsel;
    logic [31:0] rdata_d;

    function automatic logic [4:0] ratio_of(input logic [31:0] w);
        return w[RATIO_W-1:0];
    endfunction

    function automatic logic [3:0] div_sel(input logic [9:0] a);
        if (a == OFS_DIV1) begin
            return 4'h1;
        end else if (a == OFS_DIV2) begin
            return 4'h2;
        end else if (a == OFS_DIV3) begin
            return 4'h4;
        end else if (a == OFS_DIV4) begin
            return 4'h8;
        end
        return 4'h0;
    endfunction

    // One-hot divider select, shared by the write and the read path
    assign dsel = div_sel(i_addr);

    // Test-hardware request comes from outside this clock
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            test_s1_q <= 1'b0;
            test_s2_q <= 1'b0;
            test_s3_q <= 1'b0;
            test_q    <= 1'b0;
        end else begin
            test_s1_q <= i_test_mode_en;
            test_s2_q <= test_s1_q;
            test_s3_q <= test_s2_q;
            if (test_s2_q == test_s3_q) begin
                test_q <= test_s3_q;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_q <= CTL_RESET_VAL;
        end else if (i_wr && i_addr == OFS_CONTROL) begin
            ctl_q <= (ctl_q & ~CTL_WMASK) | (i_wdata[8:0] & CTL_WMASK);
        end
    end

    // Multiplier only reaches the PLL through the registered output
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            mult_q <= MULT_RESET;
        end else if (i_wr && i_addr == OFS_MULT) begin
            mult_q <= i_wdata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pre_divider_control_q <= PRE_DIVIDER_CONTROL_RESET;
        end else if (i_wr && i_addr == OFS_PRE_DIVIDER_CONTROL) begin
            pre_divider_control_q <= ratio_of(i_wdata);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            post_divider_control_q <= RATIO_RESET;
        end else if (i_wr && i_addr == OFS_POST_DIVIDER_CONTROL) begin
            post_divider_control_q <= ratio_of(i_wdata);
        end
    end

    // Bypass divider is stored only; no bypass clock is generated here
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            bypass_clock_divider_q <= BYPASS_CLOCK_DIVIDER_RESET;
        end else if (i_wr && i_addr == OFS_BYPASS_CLOCK_DIVIDER) begin
            bypass_clock_divider_q <= ratio_of(i_wdata);
        end
    end

    // Align mask is sampled when a GO starts, so a late write cannot split a GO
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            align_q <= ALIGN_RESET;
        end else if (i_wr && i_addr == OFS_ALIGN) begin
            align_q <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            auxen_q <= AUXEN_RESET;
        end else if (i_wr && i_addr == OFS_AUXEN) begin
            auxen_q <= i_wdata[3:0];
        end
    end

    // Pending ratios wait here until a GO loads them into the dividers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_DOM; i++) begin
                ratio_q[i] <= RATIO_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_DOM; i++) begin
                if (i_wr && dsel[i]) begin
                    ratio_q[i] <= ratio_of(i_wdata);
                end
            end
        end
    end

    // Change flags: GO completion clears the flags it applied, but a fresh
    // change in the same cycle wins
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            change_q <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_DOM; i++) begin
                if (i_wr && dsel[i] && ratio_of(i_wdata) != ratio_q[i]) begin
                    change_q[i] <= 1'b1;
                end else if (go_q == GO_START && hold_q[i]) begin
                    change_q[i] <= 1'b0;
                end
            end
        end
    end

    assign go_req = i_wr && i_addr == OFS_COMMAND && i_wdata[CMD_GO];

    // GO: pause aligned clocks low, load new ratios, restart together
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            go_q   <= GO_IDLE;
            hold_q <= 4'h0;
        end else begin
            case (go_q)
                GO_IDLE: begin
                    if (go_req) begin
                        go_q   <= GO_PAUSE;
                        hold_q <= align_q;
                    end
                end
                GO_PAUSE: begin
                    if ((phase_q & hold_q) == 4'h0) begin
                        go_q <= GO_START;
                    end
                end
                GO_START: begin
                    go_q   <= GO_IDLE;
                    hold_q <= 4'h0;
                end
                default: begin
                    go_q <= GO_IDLE;
                end
            endcase
        end
    end

    // Domain dividers; divide by ratio plus one, phase is the 50% level
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_DOM; i++) begin
                active_q[i] <= RATIO_RESET;
                cnt_q[i]    <= 5'h00;
            end
            phase_q <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_DOM; i++) begin
                if (go_q == GO_START && hold_q[i]) begin
                    active_q[i] <= ratio_q[i];
                    cnt_q[i]    <= 5'h00;
                    phase_q[i]  <= 1'b1;
                end else if (go_q == GO_PAUSE && hold_q[i]
                             && (!phase_q[i] || cnt_q[i] >= active_q[i])) begin
                    // A clock due to rise is parked low instead, so even a
                    // divide-by-one clock reaches the pause
                    cnt_q[i]   <= 5'h00;
                    phase_q[i] <= 1'b0;
                end else if (cnt_q[i] >= active_q[i]) begin
                    cnt_q[i]   <= 5'h00;
                    phase_q[i] <= 1'b1;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 5'h01;
                    if (cnt_q[i] == (active_q[i] >> 1)) begin
                        phase_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_domain_clock_n <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_DOM; i++) begin
                o_domain_clock_n[i] <= phase_q[i] && !(go_q == GO_PAUSE && hold_q[i]);
            end
        end
    end

    // Mode source: register bit only when source select is clear
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pll_mode <= 1'b0;
        end else begin
            o_pll_mode <= (ctl_q[CTL_EN_SRC] ? test_q : ctl_q[CTL_MODE_EN])
                          && !ctl_q[CTL_PWRDN];
        end
    end

    // Analog controls follow the register one edge later
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pll_reset        <= 1'b1;
            o_pll_disable      <= 1'b1;
            o_pll_power_down   <= 1'b1;
            o_ref_clock_select <= 1'b0;
        end else begin
            o_pll_reset        <= ctl_q[CTL_RESET];
            o_pll_disable      <= ctl_q[CTL_DISABLE];
            o_pll_power_down   <= ctl_q[CTL_PWRDN];
            o_ref_clock_select <= ctl_q[CTL_REF_SEL];
        end
    end

    // Multiplier and outer dividers; software changes these only in bypass
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pll_multiply <= 9'h000;
            o_pre_divide   <= PRE_DIVIDER_CONTROL_RESET;
            o_post_divide  <= RATIO_RESET;
        end else begin
            o_pll_multiply <= {1'b0, mult_q} + 9'h001;
            o_pre_divide   <= pre_divider_control_q;
            o_post_divide  <= post_divider_control_q;
        end
    end

    assign o_go_busy = go_q != GO_IDLE;

    always_comb begin
        rdata_d = 32'h0;
        if (i_addr == OFS_IDENTITY) begin
            rdata_d = {8'h00, ID_TYPE, ID_CLASS, ID_REV};
        end else if (i_addr == OFS_CONTROL) begin
            rdata_d = {23'h0, ctl_q};
        end else if (i_addr == OFS_MULT) begin
            rdata_d = {24'h0, mult_q};
        end else if (i_addr == OFS_PRE_DIVIDER_CONTROL) begin
            rdata_d = {16'h0, 1'b1, 10'h0, pre_divider_control_q};
        end else if (i_addr == OFS_POST_DIVIDER_CONTROL) begin
            rdata_d = {16'h0, 1'b1, 10'h0, post_divider_control_q};
        end else if (i_addr == OFS_BYPASS_CLOCK_DIVIDER) begin
            rdata_d = {16'h0, 1'b1, 10'h0, bypass_clock_divider_q};
        end else if (dsel != 4'h0) begin
            for (int i = 0; i < NUM_DOM; i++) begin
                if (dsel[i]) begin
                    rdata_d = {16'h0, 1'b1, 10'h0, ratio_q[i]};
                end
            end
        end else if (i_addr == OFS_COMMAND) begin
            // Trigger is write-only, so a read never shows a stale go bit
            rdata_d = 32'h0;
        end else if (i_addr == OFS_STATUS) begin
            rdata_d = {31'h0, o_go_busy};
        end else if (i_addr == OFS_ALIGN) begin
            rdata_d = {28'h0, align_q};
        end else if (i_addr == OFS_CHANGE) begin
            rdata_d = {28'h0, change_q};
        end else if (i_addr == OFS_AUXEN) begin
            rdata_d = {28'h0, auxen_q};
        end else if (i_addr == OFS_AUXSTAT) begin
            rdata_d = {28'h0, auxen_q};
        end else if (i_addr == OFS_DOMSTAT) begin
            rdata_d = {28'h0, phase_q};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 32'h0;
        end
    end

endmodule

// >>> pll_go_props.sv
module pll_go_props
    import pll_ctrl_pkg::*;
(
    // Register port
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [9:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [31:0] o_rdata,
    // Controls
    input  wire logic        o_pll_mode,
    input  wire logic        o_pll_reset,
    input  wire logic        o_pll_disable,
    input  wire logic        o_pll_power_down,
    input  wire logic        o_ref_clock_select,
    input  wire logic [8:0]  o_pll_multiply,
    input  wire logic        o_go_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic cmd_wr;
    assign cmd_wr = i_wr && i_addr == OFS_COMMAND;
    a_id_read: assert property ($past(i_rd) && $past(i_addr) == OFS_IDENTITY |->
        o_rdata == {8'h00, ID_TYPE, ID_CLASS, ID_REV}) else $error("identity read wrong");
    a_status_read: assert property ($past(i_rd) && $past(i_addr) == OFS_STATUS |->
        o_rdata == {31'h0, $past(o_go_busy)}) else $error("status read wrong");
    a_go_start: assert property (cmd_wr && i_wdata[CMD_GO] && !o_go_busy |=> o_go_busy)
        else $error("go not started");
    a_go_zero: assert property (cmd_wr && !i_wdata[CMD_GO] && !o_go_busy |=> !o_go_busy)
        else $error("zero write started go");
    // Longest pause is about half a period of a ratio 31 divider plus the start cycle
    a_go_ends: assert property ($rose(o_go_busy) |-> ##[1:40] !o_go_busy)
        else $error("go never finished");
    a_pd_bypass: assert property (o_pll_power_down |-> !o_pll_mode)
        else $error("pll mode while powered down");
    // Outputs lag the register by one edge, hence the extra cycle
    a_mult_plus: assert property (i_wr && i_addr == OFS_MULT |=> ##1
        o_pll_multiply == {1'b0, $past(i_wdata[7:0], 2)} + 9'h001)
        else $error("multiply wrong");
    a_ctl_copies: assert property (i_wr && i_addr == OFS_CONTROL |=> ##1
        {o_ref_clock_select, o_pll_disable, o_pll_reset, o_pll_power_down} ==
        {$past(i_wdata[8], 2), $past(i_wdata[4], 2), $past(i_wdata[3], 2), $past(i_wdata[1], 2)})
        else $error("control copy wrong");
    c_go_start: cover property (cmd_wr && i_wdata[CMD_GO] && !o_go_busy);
    c_go_done: cover property ($fell(o_go_busy));
    c_pll_mode: cover property (o_pll_mode);
endmodule

bind pll_config_and_divider_go pll_go_props props_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pll_mode(o_pll_mode), .o_pll_reset(o_pll_reset),
    .o_pll_disable(o_pll_disable), .o_pll_power_down(o_pll_power_down),
    .o_ref_clock_select(o_ref_clock_select), .o_pll_multiply(o_pll_multiply),
    .o_go_busy(o_go_busy)
);

// >>> tb_pll_config_and_divider_go.sv
module tb_pll_config_and_divider_go
    import pll_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic        i_test_mode_en = 1'b0, rd_q = 1'b0;
    logic [9:0]  i_addr = 10'h000;
    logic [31:0] i_wdata = 32'h0, o_rdata, v;
    logic        o_pll_mode, o_pll_reset, o_pll_disable, o_pll_power_down;
    logic        o_ref_clock_select, o_go_busy;
    logic [8:0]  o_pll_multiply;
    logic [4:0]  o_pre_divide, o_post_divide;
    logic [3:0]  o_domain_clock_n;
    logic [31:0] exp_q[$];
    int          err_total = 0, checks = 0, seed = 32'h3c41;
    always #12.5 i_clk = ~i_clk;
    pll_config_and_divider_go dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pll_mode(o_pll_mode),
        .o_pll_reset(o_pll_reset), .o_pll_disable(o_pll_disable),
        .o_pll_power_down(o_pll_power_down), .o_ref_clock_select(o_ref_clock_select),
        .o_pll_multiply(o_pll_multiply), .o_pre_divide(o_pre_divide),
        .o_post_divide(o_post_divide), .i_test_mode_en(i_test_mode_en),
        .o_domain_clock_n(o_domain_clock_n), .o_go_busy(o_go_busy)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        checks++;
        if (seen !== e) begin
            err_total++;
            $display("BAD %0t: seen %h want %h", $time, seen, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    // Read data is looked at on the falling edge, inside its one valid cycle
    always @(posedge i_clk) rd_q <= i_rd;
    always @(negedge i_clk) begin
        if (rd_q && exp_q.size() > 0) check(o_rdata, exp_q.pop_front());
    end
    task automatic per(input int i, input int e);
        int n, p;
        n = 0;
        @(negedge i_clk);
        for (p = 0; p < 4; p++) begin
            for (; n < 300 && o_domain_clock_n[i] !== p[0]; n++) @(negedge i_clk);
            if (p == 1) n = 0;
        end
        check(32'(n), 32'(e));
        if (n >= 300) summarize();
    endtask
    task automatic go(input logic [3:0] aln);
        int n;
        wr(OFS_COMMAND, 32'h1);
        @(negedge i_clk);
        check(32'(o_go_busy), 32'h1);
        for (n = 0; n < 100 && o_go_busy !== 1'b0; n++) @(negedge i_clk);
        if (n >= 100) begin
            err_total++;
            summarize();
        end
        // First high after restart must show every aligned clock high at once
        for (n = 0; n < 40 && (o_domain_clock_n & aln) === 4'h0; n++) @(negedge i_clk);
        check(32'(o_domain_clock_n & aln), 32'(aln));
        rd(OFS_STATUS, 32'h0);
    endtask
    task automatic entry();
        wr(OFS_CONTROL, 32'h11a);
        repeat (4) @(posedge i_clk);
        wr(OFS_CONTROL, 32'h118);
        wr(OFS_CONTROL, 32'h108);
        wr(OFS_MULT, 32'h90);
        repeat (200) @(posedge i_clk);
        wr(OFS_CONTROL, 32'h100);
        repeat (8000) @(posedge i_clk);
        wr(OFS_CONTROL, 32'h101);
        repeat (2) @(negedge i_clk);
        check(32'({o_pll_mode, o_pll_multiply}), 32'h291);
        rd(OFS_CONTROL, 32'h141);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        check(32'({o_pll_mode, o_pll_reset, o_pll_power_down}), 32'h3);
        rd(OFS_IDENTITY, {8'h00, ID_TYPE, ID_CLASS, ID_REV});
        wr(OFS_IDENTITY, 32'hffffffff);
        rd(OFS_IDENTITY, {8'h00, ID_TYPE, ID_CLASS, ID_REV});
        rd(OFS_CONTROL, {23'h0, CTL_RESET_VAL});
        rd(OFS_MULT, {24'h0, MULT_RESET});
        rd(OFS_ALIGN, 32'(ALIGN_RESET));
        rd(OFS_DIV1, 32'h8000);
        wr(10'h3fc, 32'hffffffff);
        rd(10'h3fc, 32'h0);
        $display("registers done");
        repeat (6) begin
            v = $random(seed);
            wr(OFS_CONTROL, v);
            rd(OFS_CONTROL, {23'h0, v[8:0] & CTL_WMASK | 9'h040});
            check(32'({o_ref_clock_select, o_pll_disable, o_pll_reset}), 32'({v[8], v[4:3]}));
            check(32'(o_pll_mode), 32'(v[0] & ~v[5] & ~v[1]));
        end
        i_test_mode_en <= 1'b1;
        wr(OFS_CONTROL, 32'h020);
        repeat (6) @(negedge i_clk);
        check(32'(o_pll_mode), 32'h1);
        wr(OFS_CONTROL, 32'h008);
        repeat (2) @(negedge i_clk);
        check(32'(o_pll_mode), 32'h0);
        i_test_mode_en <= 1'b0;
        repeat (3) begin
            v = $random(seed);
            wr(OFS_MULT, v);
            wr(OFS_PRE_DIVIDER_CONTROL, v);
            wr(OFS_POST_DIVIDER_CONTROL, v);
            rd(OFS_MULT, {24'h0, v[7:0]});
            check(32'(o_pll_multiply), 32'(v[7:0]) + 32'h1);
            check(32'({o_pre_divide, o_post_divide}), 32'({v[4:0], v[4:0]}));
        end
        $display("control done");
        entry();
        wr(OFS_DIV1, 32'h8001);
        wr(OFS_DIV2, 32'h8002);
        wr(OFS_DIV3, 32'h8003);
        wr(OFS_DIV4, 32'h8004);
        rd(OFS_CHANGE, 32'hf);
        wr(OFS_COMMAND, 32'h0);
        @(negedge i_clk);
        check(32'(o_go_busy), 32'h0);
        go(4'hf);
        rd(OFS_CHANGE, 32'h0);
        per(0, 2);
        per(3, 5);
        wr(OFS_DIV1, 32'h8005);
        wr(OFS_DIV3, 32'h8003);
        wr(OFS_DIV2, 32'h8006);
        rd(OFS_CHANGE, 32'h3);
        per(0, 2);
        wr(OFS_ALIGN, 32'hd);
        go(4'hd);
        rd(OFS_CHANGE, 32'h2);
        per(0, 6);
        per(1, 3);
        per(2, 4);
        $display("go done");
        wr(OFS_CONTROL, 32'h120);
        repeat (4) @(posedge i_clk);
        wr(OFS_CONTROL, 32'h12a);
        repeat (2) @(negedge i_clk);
        check(32'(o_pll_mode), 32'h0);
        per(3, 5);
        entry();
        $display("power down done");
        summarize();
    end
endmodule
